// File: tic_timer_ctl.v
/*
  One timer channel slice: APB register file, clock control with debug
  run, up/down counter, compare/capture channels and interrupt flags.
  Assumes an APB master on pclk, capture triggers already synchronous to
  pclk, and a clock gate downstream that obeys clk_supply.
*/
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "tic_defines.vh"

module tic_timer_ctl #(
  parameter NCH = 2,
  parameter CW  = 16
) (
  // clock and reset
  input  wire           pclk,
  input  wire           presetn,
  // apb slave
  input  wire           psel,
  input  wire           penable,
  input  wire           pwrite,
  input  wire [11:0]    paddr,
  input  wire [31:0]    pwdata,
  output reg  [31:0]    prdata,
  output wire           pready,
  output wire           pslverr,
  // system and capture inputs
  input  wire           debug_mode,
  input  wire [NCH-1:0] capture_trig,
  // clock control outputs
  output wire           clk_supply,
  output wire [3:0]     clock_divide_select,
  output wire [2:0]     clock_source_select,
  // counter and channel outputs
  output wire [CW-1:0]  counter_value,
  output reg  [NCH-1:0] match_pulse_r,
  // interrupt request
  output wire           irq
);

  localparam NF = 2 + 2 * NCH;
  localparam CAPOW_LSB = `TIC_IF_CMPCAP_LSB + NCH;
  localparam [3:0] NCH_W = NCH[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire        setup_ph = psel && !penable;
  wire        access   = psel && penable;
  wire        wr_acc   = access && pwrite;
  wire [2:0]  ccr_idx  = paddr[4:2];

  wire hit_clk   = (paddr == `TIC_OFS_CLKCTL);
  wire hit_ctl   = (paddr == `TIC_OFS_CNTCTL);
  wire hit_max   = (paddr == `TIC_OFS_MAX);
  wire hit_cnt   = (paddr == `TIC_OFS_CNTVAL);
  wire hit_intf  = (paddr == `TIC_OFS_INTF);
  wire hit_inten = (paddr == `TIC_OFS_INTEN);
  wire hit_mode  = (paddr == `TIC_OFS_CHMODE);
  wire hit_ccr   = ((paddr & ~`TIC_CCR_IDX_MASK) == `TIC_CCR_BASE)
                   && ({1'b0, ccr_idx} < NCH_W);
  wire hit_any   = hit_clk | hit_ctl | hit_max | hit_cnt | hit_intf
                   | hit_inten | hit_mode | hit_ccr;

  // zero wait states; prdata is loaded during setup
  assign pready  = 1'b1;
  assign pslverr = access && !hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // clock control register

  reg       debug_run_r;
  reg [3:0] clock_divide_select_r;
  reg [2:0] clock_source_select_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      debug_run_r <= 1'b0;
      clock_divide_select_r    <= 4'h0;
      clock_source_select_r    <= 3'h0;
    end
    else if (wr_acc && hit_clk)
    begin
      debug_run_r <= pwdata[`TIC_CLK_DEBUG_RUN_BIT];
      clock_divide_select_r    <= pwdata[`TIC_CLK_DIV_HI:`TIC_CLK_DIV_LO];
      clock_source_select_r    <= pwdata[`TIC_CLK_SRC_HI:`TIC_CLK_SRC_LO];
    end
  end

  // debug halts the channel unless software asked it to keep running
  assign clk_supply          = !debug_mode || debug_run_r;
  assign clock_divide_select = clock_divide_select_r;
  assign clock_source_select = clock_source_select_r;

  ////////////////////////////////////////////////////////////////////////////
  // counter control, max value, channel modes

  reg          run_r;
  reg [1:0]    cntmd_r;
  reg          preset_r;
  reg [CW-1:0] max_r;
  reg [NCH-1:0] capmode_r;
  reg [NF-1:0]  inten_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_r     <= 1'b0;
      cntmd_r   <= `TIC_MODE_UP;
      preset_r  <= 1'b0;
      max_r     <= `TIC_MAX_RST;
      capmode_r <= {NCH{1'b0}};
      inten_r   <= {NF{1'b0}};
    end
    else
    begin
      preset_r <= wr_acc && hit_ctl && pwdata[`TIC_CTL_PRESET_BIT];
      if (wr_acc && hit_ctl)
      begin
        run_r   <= pwdata[`TIC_CTL_RUN_BIT];
        cntmd_r <= pwdata[`TIC_CTL_MODE_HI:`TIC_CTL_MODE_LO];
      end
      if (wr_acc && hit_max)
        max_r <= pwdata[CW-1:0];
      if (wr_acc && hit_mode)
        capmode_r <= pwdata[NCH-1:0];
      if (wr_acc && hit_inten)
        inten_r <= pwdata[NF-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter core

  // counting also pauses while the operating clock is withheld
  wire         tick = run_r && clk_supply;
  wire [CW-1:0] cnt_nxt;
  wire         max_hit;
  wire         zero_hit;

  tic_updown_counter #(
    .CW (CW)
  ) u_cnt (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick),
    .preset     (preset_r),
    .mode       (cntmd_r),
    .max_val    (max_r),
    .cnt_r      (counter_value),
    .cnt_nxt    (cnt_nxt),
    .max_hit_r  (max_hit),
    .zero_hit_r (zero_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare/capture channels

  wire [NF-1:0]     flag_q;
  wire [NCH-1:0]    cap_evt;
  wire [NCH-1:0]    cmpcap_q = flag_q[`TIC_IF_CMPCAP_LSB +: NCH];
  wire [NCH-1:0]    match_nxt;
  wire [NCH*CW-1:0] ccr_flat;

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc = gc + 1)
    begin : g_ch
      reg [CW-1:0] ccr_r;

      // capture is gated by the same clock supply as counting
      assign cap_evt[gc] = capture_trig[gc] && capmode_r[gc] && clk_supply;
      assign match_nxt[gc] = tick && !preset_r && !capmode_r[gc]
                             && (cnt_nxt == ccr_r);
      assign ccr_flat[gc*CW +: CW] = ccr_r;

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ccr_r <= {CW{1'b0}};
        else if (cap_evt[gc])
          ccr_r <= counter_value;
        else if (wr_acc && hit_ccr && (ccr_idx == gc) && !capmode_r[gc])
          ccr_r <= pwdata[CW-1:0];
      end
    end
  endgenerate

  // one process owns the whole pulse vector
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_pulse_r <= {NCH{1'b0}};
    else
      match_pulse_r <= match_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags

  wire [NF-1:0] set_evt;
  wire [NF-1:0] clr_w1c = (wr_acc && hit_intf) ? pwdata[NF-1:0] : {NF{1'b0}};

  assign set_evt[`TIC_IF_MAX_BIT]                 = max_hit;
  assign set_evt[`TIC_IF_ZERO_BIT]                = zero_hit;
  assign set_evt[`TIC_IF_CMPCAP_LSB +: NCH]       = match_pulse_r | cap_evt;
  // overwrite sees the flag as it stood before this capture
  assign set_evt[CAPOW_LSB +: NCH]                = cap_evt & cmpcap_q;

  tic_flags #(
    .NF (NF)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (set_evt),
    .clr_w1c (clr_w1c),
    .flag_q  (flag_q)
  );

  assign irq = |(flag_q & inten_r);

  ////////////////////////////////////////////////////////////////////////////
  // read data

  reg [31:0] rd_data;

  always @*
  begin
    rd_data = `TIC_RDATA_RST;
    if (hit_clk)
    begin
      rd_data[`TIC_CLK_DEBUG_RUN_BIT]                = debug_run_r;
      rd_data[`TIC_CLK_DIV_HI:`TIC_CLK_DIV_LO]  = clock_divide_select_r;
      rd_data[`TIC_CLK_SRC_HI:`TIC_CLK_SRC_LO]  = clock_source_select_r;
    end
    else if (hit_ctl)
    begin
      rd_data[`TIC_CTL_RUN_BIT]                  = run_r;
      rd_data[`TIC_CTL_PRESET_BIT]               = preset_r;
      rd_data[`TIC_CTL_MODE_HI:`TIC_CTL_MODE_LO] = cntmd_r;
    end
    else if (hit_max)
      rd_data[CW-1:0] = max_r;
    else if (hit_cnt)
      rd_data[CW-1:0] = counter_value;
    else if (hit_intf)
      rd_data[NF-1:0] = flag_q;
    else if (hit_inten)
      rd_data[NF-1:0] = inten_r;
    else if (hit_mode)
      rd_data[NCH-1:0] = capmode_r;
    else if (hit_ccr)
      rd_data[CW-1:0] = ccr_flat[ccr_idx*CW +: CW];
    else
      rd_data = `TIC_RDATA_RST;
  end

  // snapshot at setup; access phase completes with it at once
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `TIC_RDATA_RST;
    else if (setup_ph && !pwrite)
      prdata <= rd_data;
  end

endmodule // tic_timer_ctl

`default_nettype wire

// File: tic_defines.vh
/*
  Constants of the timer interrupt and clock control slice: register byte
  offsets, field positions, reset values and count mode codes.
  Assumes inclusion by bare name from each design file of the slice that uses it.
*/
`ifndef TIC_DEFINES_VH
`define TIC_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define TIC_OFS_CLKCTL     12'h000
`define TIC_OFS_CNTCTL     12'h004
`define TIC_OFS_MAX        12'h008
`define TIC_OFS_CNTVAL     12'h00C
`define TIC_OFS_INTF       12'h010
`define TIC_OFS_INTEN      12'h014
`define TIC_OFS_CHMODE     12'h018
`define TIC_CCR_BASE       12'h020
`define TIC_CCR_IDX_MASK   12'h01C

////////////////////////////////////////////////////////////////////////////////
// field positions
`define TIC_CLK_DEBUG_RUN_BIT  8
`define TIC_CLK_DIV_HI     7
`define TIC_CLK_DIV_LO     4
`define TIC_CLK_SRC_HI     2
`define TIC_CLK_SRC_LO     0
`define TIC_CTL_RUN_BIT    0
`define TIC_CTL_PRESET_BIT 1
`define TIC_CTL_MODE_HI    5
`define TIC_CTL_MODE_LO    4
`define TIC_IF_MAX_BIT     0
`define TIC_IF_ZERO_BIT    1
`define TIC_IF_CMPCAP_LSB  2

////////////////////////////////////////////////////////////////////////////////
// reset values and codes
`define TIC_MAX_RST        16'hffff
`define TIC_ZERO16         16'h0000
`define TIC_ONE16          16'h0001
`define TIC_RDATA_RST      32'h0000_0000
`define TIC_MODE_UP        2'h0
`define TIC_MODE_DOWN      2'h1
`define TIC_MODE_UPDN      2'h2

`endif

// File: tic_flags.v
/*
  Sticky interrupt flags, one cell per bit, write-1-to-clear.
  Assumes set and clear pulses synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module tic_flags #(
  parameter NF = 6
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // events and software clear
  input  wire [NF-1:0] set_evt,
  input  wire [NF-1:0] clr_w1c,
  // flag state
  output wire [NF-1:0] flag_q
);

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi = gi + 1)
    begin : g_flag
      reg flag_r;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flag_r <= 1'b0;
        else if (set_evt[gi])
          flag_r <= 1'b1;
        else if (clr_w1c[gi])
          flag_r <= 1'b0;
      end
      assign flag_q[gi] = flag_r;
    end
  endgenerate

endmodule // tic_flags

`default_nettype wire

// File: tic_updown_counter.v
/*
  Repeat up, down and up/down counter with MAX and zero event pulses.
  Assumes tick is a count-enable level and preset a single-cycle strobe in the pclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tic_defines.vh"

module tic_updown_counter #(
  parameter CW = 16
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // control
  input  wire          tick,
  input  wire          preset,
  input  wire [1:0]    mode,
  input  wire [CW-1:0] max_val,
  // state and events
  output reg  [CW-1:0] cnt_r,
  output reg  [CW-1:0] cnt_nxt,
  output reg           max_hit_r,
  output reg           zero_hit_r
);

  localparam [CW-1:0] ZERO = {CW{1'b0}};
  localparam [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};

  reg dir_up_r;
  reg dir_up_nxt;

  always @*
  begin
    cnt_nxt    = cnt_r;
    dir_up_nxt = dir_up_r;
    if (preset)
    begin
      cnt_nxt    = (mode == `TIC_MODE_DOWN) ? max_val : ZERO;
      dir_up_nxt = 1'b1;
    end
    else if (tick)
    begin
      case (mode)
        `TIC_MODE_UP:   cnt_nxt = (cnt_r == max_val) ? ZERO : cnt_r + ONE;
        `TIC_MODE_DOWN: cnt_nxt = (cnt_r == ZERO) ? max_val : cnt_r - ONE;
        `TIC_MODE_UPDN:
        begin
          // turn at both ends, never wrap unless max_val is zero
          if (dir_up_r && (cnt_r >= max_val))
          begin
            cnt_nxt    = cnt_r - ONE;
            dir_up_nxt = 1'b0;
          end
          else if (!dir_up_r && (cnt_r == ZERO))
          begin
            cnt_nxt    = cnt_r + ONE;
            dir_up_nxt = 1'b1;
          end
          else if (dir_up_r)
            cnt_nxt = cnt_r + ONE;
          else
            cnt_nxt = cnt_r - ONE;
        end
        default: cnt_nxt = cnt_r;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r      <= ZERO;
      dir_up_r   <= 1'b1;
      max_hit_r  <= 1'b0;
      zero_hit_r <= 1'b0;
    end
    else
    begin
      cnt_r      <= cnt_nxt;
      dir_up_r   <= dir_up_nxt;
      max_hit_r  <= tick && !preset && (cnt_nxt == max_val);
      zero_hit_r <= tick && !preset && (cnt_nxt == ZERO);
    end
  end

endmodule // tic_updown_counter

`default_nettype wire

// File: tic_timer_ctl_checker.sv
/*
  Checker for tic_timer_ctl: clock supply, clock control readback,
  up/down walk and irq gating.
  Assumes a bind to the top module; shadows follow APB writes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tic_defines.vh"

module tic_timer_ctl_checker #(
  parameter NCH = 2,
  parameter CW  = 16
) (
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  // outputs watched
  input wire logic          debug_mode,
  input wire logic          clk_supply,
  input wire logic [3:0]    clock_divide_select,
  input wire logic [2:0]    clock_source_select,
  input wire logic [CW-1:0] counter_value,
  input wire logic          irq
);
  wire              wr = psel && penable && pwrite;
  wire              wc = wr && paddr == `TIC_OFS_CNTCTL;
  logic [8:0]       ck_r;
  logic             run_r;
  logic [1:0]       md_r;
  logic [1:0]       cw_r;
  logic [2*NCH+1:0] en_r;
  logic [CW-1:0]    mx_r;

  // preset may move the counter up to two edges after the write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ck_r  <= 9'h000;
      run_r <= 1'b0;
      md_r  <= 2'h0;
      cw_r  <= 2'h0;
      en_r  <= '0;
      mx_r  <= `TIC_MAX_RST;
    end
    else
    begin
      cw_r <= {cw_r[0], wc};
      if (wr && paddr == `TIC_OFS_CLKCTL) ck_r <= pwdata[8:0];
      if (wr && paddr == `TIC_OFS_INTEN) en_r <= pwdata[2*NCH+1:0];
      if (wr && paddr == `TIC_OFS_MAX) mx_r <= pwdata[CW-1:0];
      if (wc) run_r <= pwdata[0];
      if (wc) md_r <= pwdata[5:4];
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_peak;
    counter_value == mx_r - 16'h0001 ##1 counter_value == mx_r;
  endsequence

  a_supply_dbg: assert property (clk_supply == (!debug_mode || ck_r[8]))
    else $error("clock supply wrong for debug state");
  a_cnt_frozen: assert property ((!clk_supply && cw_r == 2'h0 && !wc)
    |=> $stable(counter_value)) else $error("counter moved without clock");
  a_div_follow: assert property (clock_divide_select == ck_r[7:4])
    else $error("divide select differs from written value");
  a_src_follow: assert property (clock_source_select == ck_r[2:0])
    else $error("source select differs from written value");
  a_clk_readback: assert property ((psel && penable && !pwrite && paddr == `TIC_OFS_CLKCTL)
    |-> prdata == {23'h0, ck_r[8:4], 1'b0, ck_r[2:0]}) else $error("clock control readback");
  a_irq_masked: assert property (en_r == '0 |-> !irq)
    else $error("irq with all enables clear");
  a_updn_bound: assert property (md_r == `TIC_MODE_UPDN |-> counter_value <= mx_r)
    else $error("counter above max in up/down mode");
  a_updn_step: assert property ((md_r == `TIC_MODE_UPDN && cw_r == 2'h0 && !wc)
    |=> (counter_value == $past(counter_value) + 16'h0001
      || counter_value == $past(counter_value) - 16'h0001 || $stable(counter_value)))
    else $error("up/down counter jumped");
  a_updn_turn: assert property ((s_peak ##0 (md_r == `TIC_MODE_UPDN && run_r
    && clk_supply && cw_r == 2'h0 && !wc)) |=> counter_value == mx_r - 16'h0001)
    else $error("no turn at max");
endmodule // tic_timer_ctl_checker

bind tic_timer_ctl tic_timer_ctl_checker #(.NCH(NCH), .CW(CW)) tic_timer_ctl_checker_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .debug_mode,
  .clk_supply, .clock_divide_select, .clock_source_select, .counter_value, .irq);
`default_nettype wire

// File: tic_intc_model.sv
/*
  Interrupt controller stand-in that counts request rises.
  Assumes irq is a level synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none

module tic_intc_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request and count
  input  wire logic       irq,
  output var  logic [7:0] req_cnt
);
  logic irq_r;

  // a level held across enable changes is one request, so count rises
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_r   <= 1'b0;
      req_cnt <= 8'h00;
    end
    else
    begin
      irq_r <= irq;
      if (irq && !irq_r) req_cnt <= req_cnt + 8'h01;
    end
endmodule // tic_intc_model
`default_nettype wire

// File: tb_top.sv
/*
  Self-checking bench for tic_timer_ctl driven over APB.
  Assumes the checker is bound and the defines header is reachable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tic_defines.vh"

module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        debug_mode = 1'b0;
  logic [1:0]  capture_trig = 2'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, clk_supply, irq;
  wire  [3:0]  clock_divide_select;
  wire  [2:0]  clock_source_select;
  wire  [15:0] counter_value;
  wire  [1:0]  match_pulse_r;
  wire  [7:0]  req_cnt;
  logic [31:0] rdat;
  logic        rerr;
  logic [15:0] v0;
  int          n_mismatch = 0;
  int          checks = 0;
  int          i;

  tic_timer_ctl tic_timer_ctl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .debug_mode, .capture_trig, .clk_supply,
    .clock_divide_select, .clock_source_select, .counter_value, .match_pulse_r, .irq);
  tic_intc_model tic_intc_model_i (.pclk, .presetn, .irq, .req_cnt);

  initial
    forever #4 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic fail_wait;
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done;
  endtask

  // trigger t is held through the access cycle, so it meets a write there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] t);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    capture_trig <= t;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail_wait;
    rdat = prdata;
    rerr = pslverr;
    capture_trig <= 2'h0;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    int k;
    k = 0;
    do
    begin
      @(negedge pclk);
      k++;
    end
    while (counter_value !== v && k < 100);
    if (counter_value !== v) fail_wait;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 2'h0);
    check(rdat, e);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`TIC_OFS_CLKCTL, 32'h0000_0000);
    apb(1'b1, `TIC_OFS_CLKCTL, 32'hffff_ffff, 2'h0);
    rdc(`TIC_OFS_CLKCTL, 32'h0000_01f7);
    check({28'h0, clock_divide_select}, 32'h0000_000f);
    check({29'h0, clock_source_select}, 32'h0000_0007);
    apb(1'b1, `TIC_CCR_BASE, 32'h0000_0002, 2'h0);
    apb(1'b1, `TIC_CCR_BASE + 12'h004, 32'h0000_1234, 2'h0);
    apb(1'b1, `TIC_OFS_CHMODE, 32'h0000_0002, 2'h0);
    apb(1'b1, `TIC_OFS_MAX, 32'h0000_0005, 2'h0);
    apb(1'b1, `TIC_OFS_CNTCTL, 32'h0000_0023, 2'h0);
    wait_cnt(16'h0005);
    for (i = 1; i < 8; i++)
    begin
      @(negedge pclk);
      check({16'h0, counter_value}, (i < 5) ? 5 - i : i - 5);
      check({30'h0, match_pulse_r}, (i == 3 || i == 7) ? 1 : 0);
    end
    @(posedge pclk);
    debug_mode <= 1'b1;
    @(negedge pclk);
    check({31'h0, clk_supply}, 32'h0000_0001);
    v0 = counter_value;
    @(negedge pclk);
    check({31'h0, counter_value !== v0}, 32'h0000_0001);
    apb(1'b1, `TIC_OFS_CLKCTL, 32'h0000_0000, 2'h0);
    @(negedge pclk);
    check({31'h0, clk_supply}, 32'h0000_0000);
    v0 = counter_value;
    repeat (3) @(negedge pclk);
    check({16'h0, counter_value}, {16'h0, v0});
    @(posedge pclk);
    debug_mode <= 1'b0;
    apb(1'b1, `TIC_OFS_CNTCTL, 32'h0000_0022, 2'h0);
    rdc(`TIC_OFS_CNTVAL, 32'h0000_0000);
    rdc(`TIC_OFS_INTF, 32'h0000_0007);
    check({31'h0, irq}, 32'h0000_0000);
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, `TIC_OFS_INTEN, 32'h1 << i, 2'h0);
      @(negedge pclk);
      check({31'h0, irq}, i < 3);
    end
    apb(1'b1, `TIC_OFS_INTF, 32'h0000_0007, 2'h0);
    rdc(`TIC_OFS_INTF, 32'h0000_0000);
    apb(1'b1, `TIC_OFS_INTEN, 32'h0000_0008, 2'h2);
    rdc(`TIC_CCR_BASE + 12'h004, 32'h0000_0000);
    rdc(`TIC_OFS_INTF, 32'h0000_0008);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `TIC_OFS_INTEN, 32'h0000_0020, 2'h2);
    rdc(`TIC_OFS_INTF, 32'h0000_0028);
    apb(1'b1, `TIC_OFS_INTF, 32'h0000_0028, 2'h2);
    rdc(`TIC_OFS_INTF, 32'h0000_0028);
    apb(1'b1, `TIC_OFS_INTF, 32'h0000_0028, 2'h0);
    rdc(`TIC_OFS_INTF, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    rdc(12'h0fc, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    check({24'h0, req_cnt}, 32'h0000_0002);
    apb(1'b1, `TIC_OFS_MAX, 32'h0000_0003, 2'h0);
    apb(1'b1, `TIC_OFS_CNTCTL, 32'h0000_0003, 2'h0);
    wait_cnt(16'h0003);
    @(negedge pclk);
    check({16'h0, counter_value}, 32'h0000_0000);
    apb(1'b1, `TIC_OFS_CNTCTL, 32'h0000_0013, 2'h0);
    wait_cnt(16'h0000);
    @(negedge pclk);
    check({16'h0, counter_value}, 32'h0000_0003);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
